// File: rtl/crs_device.sv
// Behaviour
// - Decode channel control and integration offsets
// - Counter writes only in test mode
// - Broadcast and group writes, write only
// - Control addresses write control, read measurements
// - 16-bit transfers, increments assembled 32-bit
// - Upper word held until lower word
// - Buffered word applied next phase cycle
// - Shared upper increment needs no wait
// - Integration reset clears channel status bits
// - Status latch write samples new-data, missed and early/late flags
// - New-data bits captured on interrupt edge
// - Host latches status only with interrupts off
// - Host services interrupts before next dump
// - Interrupt flag set, cleared on read
// - New-data cleared by prompt read, reset
// - Visible on latch; disable clears immediately
// - Discrete input glitch flag, read clears
// - Live discrete input level on read
// - Epoch flag set, read clears
// - Measurement interrupt at epoch and before
// - Missed-data set on overrun until reset
// - Early/late bit fixed at dump
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module crs_device
    import crs_pkg::*;
#(
    parameter int              NPH      = PHASES,
    parameter logic [31:0]     WARN_CY  = WARN_CYC
)(
    crs_link_if.dev            link,
    input  wire logic [NCH-1:0] dump,
    input  wire logic [NCH-1:0] early_code,
    input  wire logic [NCH-1:0] chan_enable,
    input  wire logic          integration_interrupt,
    input  wire logic          measurement_epoch,
    input  wire logic          interrupt_enable,
    input  wire logic          discrete_input_level,
    input  wire logic          software_master_reset,
    input  wire logic [DW-1:0] meas_rdata,
    output logic [AW-1:0]      meas_addr,
    output logic               wr_stb,
    output logic [NCH-1:0]     wr_mask,
    output logic [4:0]         wr_off,
    output logic               wr_is_acc,
    output logic [DW-1:0]      wr_data,
    output logic               incr_load,
    output logic               incr_is_code,
    output logic [NCH-1:0]     incr_mask,
    output logic [IW-1:0]      incr_value,
    output logic               test_mode
);
    // ****************
    // Decode helpers
    // ****************
    typedef struct packed {
        logic           is_ctl;
        logic           is_acc;
        logic [NCH-1:0] mask;
        logic [4:0]     off;
    } crs_dec_s;

    function automatic crs_dec_s decode(input logic [AW-1:0] a, input logic [NCH-1:0] grp);
        crs_dec_s d;
        logic [AW-1:0] rel;
        d   = '0;
        rel = a - ACC_BASE;
        if (a < MULTI_CHANNEL_CONTROL_BASE) begin
            d.is_ctl = 1'b1;
            d.mask   = NCH'(1) << a[8:5];
            d.off    = a[4:0];
        end else if (a >= MULTI_CHANNEL_CONTROL_BASE && a < MULTI_CHANNEL_CONTROL_BASE + CHANNEL_CONTROL_BASE_STRIDE) begin
            d.is_ctl = 1'b1;
            d.mask   = grp;
            d.off    = a[4:0];
        end else if (a >= ALL_CHANNEL_CONTROL_BASE && a < ALL_CHANNEL_CONTROL_BASE + CHANNEL_CONTROL_BASE_STRIDE) begin
            d.is_ctl = 1'b1;
            d.mask   = '1;
            d.off    = a[4:0];
        end else if (a >= ACC_BASE && a < MULTI_ACC) begin
            d.is_acc = 1'b1;
            d.mask   = NCH'(1) << rel[7:4];
            d.off    = {1'b0, a[3:0]};
        end else if (a >= MULTI_ACC && a < ALL_ACC) begin
            d.is_acc = 1'b1;
            d.mask   = grp;
            d.off    = {1'b0, a[3:0]};
        end else if (a >= ALL_ACC && a < ACC_END) begin
            d.is_acc = 1'b1;
            d.mask   = '1;
            d.off    = {1'b0, a[3:0]};
        end
        return d;
    endfunction

    function automatic logic single(input logic [AW-1:0] a);
        return (a < MULTI_CHANNEL_CONTROL_BASE) || (a >= ACC_BASE && a < MULTI_ACC);
    endfunction

    // ****************
    // Write input buffer and phase clock
    // ****************
    logic [$clog2(NPH)-1:0] phase_r;
    logic                   pend_r;
    logic [AW-1:0]          baddr_r;
    logic [DW-1:0]          bdata_r;
    logic [NCH-1:0]         group_r;
    logic [DW-1:0]          upper_r;
    logic                   apply;
    crs_dec_s               wd;

    assign apply = pend_r && (phase_r == ($clog2(NPH))'(NPH - 1));
    assign wd    = decode(baddr_r, group_r);

    always_ff @(posedge link.pclk or negedge link.presetn) begin
        if (!link.presetn) begin
            phase_r <= '0;
        end else if (phase_r == ($clog2(NPH))'(NPH - 1)) begin
            phase_r <= '0;
        end else begin
            phase_r <= phase_r + 1'b1;
        end
    end

    always_ff @(posedge link.pclk or negedge link.presetn) begin
        if (!link.presetn) begin
            pend_r  <= 1'b0;
            baddr_r <= '0;
            bdata_r <= '0;
        end else if (link.wr_en && link.addr != X_INCR_HIGH) begin
            pend_r  <= 1'b1;
            baddr_r <= link.addr;
            bdata_r <= link.wdata;
        end else if (apply) begin
            pend_r  <= 1'b0;
        end
    end

    always_ff @(posedge link.pclk or negedge link.presetn) begin
        if (!link.presetn) begin
            group_r   <= '0;
            test_mode <= 1'b0;
        end else if (apply && baddr_r == GROUP_SEL) begin
            group_r   <= bdata_r[NCH-1:0];
        end else if (apply && baddr_r == TEST_CTRL) begin
            test_mode <= bdata_r[TEST_MODE_BIT];
        end
    end

    // Upper increment word; shared address loads at once, no buffer wait
    always_ff @(posedge link.pclk or negedge link.presetn) begin
        if (!link.presetn) begin
            upper_r <= '0;
        end else if (link.wr_en && link.addr == X_INCR_HIGH) begin
            upper_r <= link.wdata;
        end else if (apply && wd.is_ctl && (wd.off == OFF_CARR_HI || wd.off == OFF_CODE_HI)) begin
            upper_r <= bdata_r;
        end
    end

    always_ff @(posedge link.pclk or negedge link.presetn) begin
        if (!link.presetn) begin
            incr_load    <= 1'b0;
            incr_is_code <= 1'b0;
            incr_mask    <= '0;
            incr_value   <= '0;
        end else begin
            incr_load <= 1'b0;
            if (apply && wd.is_ctl && (wd.off == OFF_CARR_LO || wd.off == OFF_CODE_LO)) begin
                incr_load    <= 1'b1;
                incr_is_code <= (wd.off == OFF_CODE_LO);
                incr_mask    <= wd.mask;
                incr_value   <= {upper_r, bdata_r};
            end
        end
    end

    // Plain 16-bit writes to channel registers
    always_ff @(posedge link.pclk or negedge link.presetn) begin
        if (!link.presetn) begin
            wr_stb    <= 1'b0;
            wr_mask   <= '0;
            wr_off    <= '0;
            wr_is_acc <= 1'b0;
            wr_data   <= '0;
        end else begin
            wr_stb <= 1'b0;
            if (apply && (wd.is_ctl || wd.is_acc)) begin
                if (wd.is_ctl && (wd.off == OFF_CODE_PHASE || wd.off == OFF_CARR_CYC)) begin
                    wr_stb <= test_mode;
                end else if (wd.is_ctl) begin
                    wr_stb <= !(wd.off == OFF_CARR_HI || wd.off == OFF_CODE_HI ||
                                wd.off == OFF_CARR_LO || wd.off == OFF_CODE_LO);
                end else begin
                    wr_stb <= (wd.off != OFF_ACC_RESET);
                end
                wr_mask   <= wd.mask;
                wr_off    <= wd.off;
                wr_is_acc <= wd.is_acc;
                wr_data   <= bdata_r;
            end
        end
    end

    // ****************
    // Read path
    // ****************
    logic          rd_q;
    logic [AW-1:0] raddr_r;
    logic          rd_end;
    logic [DW-1:0] rdata_r;
    logic          int_q;
    logic          int_edge;
    logic          latch;
    logic          acc_rst_any;
    logic [NCH-1:0] acc_rst;
    logic [NCH-1:0] prompt_rd;
    crs_dec_s      rdd;

    assign rd_end      = rd_q && !link.rd_en;
    assign rdd         = decode(raddr_r, group_r);
    assign int_edge    = integration_interrupt && !int_q;
    assign latch       = int_edge || (apply && baddr_r == ST_EARLY_LATE);
    assign acc_rst_any = apply && wd.is_acc && wd.off == OFF_ACC_RESET;
    assign acc_rst     = acc_rst_any ? wd.mask : '0;
    assign prompt_rd   = (rd_end && rdd.is_acc && rdd.off == OFF_Q_PROMPT && single(raddr_r)) ? rdd.mask : '0;
    assign meas_addr   = link.addr;
    assign link.rdata  = rdata_r;

    always_ff @(posedge link.pclk or negedge link.presetn) begin
        if (!link.presetn) begin
            rd_q    <= 1'b0;
            raddr_r <= '0;
            int_q   <= 1'b0;
        end else begin
            rd_q    <= link.rd_en;
            raddr_r <= link.rd_en ? link.addr : raddr_r;
            int_q   <= integration_interrupt;
        end
    end

    // ****************
    // Status flags
    // ****************
    logic [NCH-1:0] new_live_r;
    logic [NCH-1:0] miss_live_r;
    logic [NCH-1:0] el_live_r;
    logic [NCH-1:0] new_vis_r;
    logic [NCH-1:0] miss_vis_r;
    logic [NCH-1:0] el_vis_r;
    logic           int_flag_r;
    logic           glitch_r;
    logic           epoch_r;
    logic           measurement_interrupt_flag_r;
    logic [31:0]    ep_cnt_r;
    logic [31:0]    ep_per_r;
    logic [NCH-1:0] chan_clr;
    logic           warn;

    assign chan_clr = acc_rst | ~chan_enable | {NCH{software_master_reset}};

    always_ff @(posedge link.pclk or negedge link.presetn) begin
        if (!link.presetn) begin
            new_live_r  <= '0;
            miss_live_r <= '0;
            el_live_r   <= '0;
        end else begin
            new_live_r  <= dump | (new_live_r & ~(chan_clr | prompt_rd));
            miss_live_r <= (dump & new_live_r) | (miss_live_r & ~chan_clr);
            el_live_r   <= (dump & early_code) | (el_live_r & ~dump & ~chan_clr);
        end
    end

    always_ff @(posedge link.pclk or negedge link.presetn) begin
        if (!link.presetn) begin
            new_vis_r  <= '0;
            miss_vis_r <= '0;
            el_vis_r   <= '0;
        end else if (latch) begin
            new_vis_r  <= new_live_r & ~(chan_clr | prompt_rd);
            miss_vis_r <= miss_live_r & ~chan_clr;
            el_vis_r   <= el_live_r & ~chan_clr;
        end else begin
            new_vis_r  <= new_vis_r & ~(chan_clr | prompt_rd);
            miss_vis_r <= miss_vis_r & ~chan_clr;
            el_vis_r   <= el_vis_r & ~chan_clr;
        end
    end

    // Flags below ignore the software reset
    always_ff @(posedge link.pclk or negedge link.presetn) begin
        if (!link.presetn) begin
            int_flag_r <= 1'b0;
            glitch_r   <= 1'b0;
            epoch_r    <= 1'b0;
            measurement_interrupt_flag_r <= 1'b0;
        end else begin
            int_flag_r <= int_edge || (int_flag_r && !(rd_end && raddr_r == ST_NEW_DATA));
            glitch_r   <= !discrete_input_level || (glitch_r && !(rd_end && raddr_r == ST_MISSED));
            epoch_r    <= measurement_epoch || (epoch_r && !(rd_end && raddr_r == ST_MISSED));
            measurement_interrupt_flag_r <= (interrupt_enable && (measurement_epoch || warn)) ||
                          (measurement_interrupt_flag_r && !(rd_end && raddr_r == ST_MISSED));
        end
    end

    // Epoch period tracker for the early warning
    assign warn = (ep_per_r > WARN_CY) && (ep_cnt_r == ep_per_r - WARN_CY);

    always_ff @(posedge link.pclk or negedge link.presetn) begin
        if (!link.presetn) begin
            ep_cnt_r <= '0;
            ep_per_r <= '0;
        end else if (measurement_epoch) begin
            ep_cnt_r <= 32'h0000_0001;
            ep_per_r <= ep_cnt_r;
        end else begin
            ep_cnt_r <= ep_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge link.pclk or negedge link.presetn) begin
        if (!link.presetn) begin
            rdata_r <= '0;
        end else if (link.rd_en) begin
            if (link.addr == ST_EARLY_LATE) begin
                rdata_r <= DW'(el_vis_r);
            end else if (link.addr == ST_MEAS) begin
                rdata_r <= meas_rdata;
            end else if (link.addr == ST_NEW_DATA) begin
                rdata_r <= DW'({int_flag_r, 3'b000, new_vis_r});
            end else if (link.addr == ST_MISSED) begin
                rdata_r <= DW'({glitch_r, discrete_input_level, epoch_r, measurement_interrupt_flag_r, miss_vis_r});
            end else if (single(link.addr)) begin
                rdata_r <= meas_rdata;
            end else begin
                rdata_r <= '0;
            end
        end
    end
endmodule
`default_nettype wire

// File: inc/crs_pkg.sv
`default_nettype none
package crs_pkg;
    // ****************
    // Bus and channels
    // ****************
    localparam int          NCH   = 12;
    localparam int          AW    = 10;
    localparam int          DW    = 16;
    localparam int          IW    = 32;
    // ****************
    // Register map (byte addresses)
    // ****************
    localparam logic [AW-1:0] CHANNEL_CONTROL_BASE_STRIDE   = 10'h020;
    localparam logic [AW-1:0] MULTI_CHANNEL_CONTROL_BASE    = 10'h180;
    localparam logic [AW-1:0] ALL_CHANNEL_CONTROL_BASE      = 10'h1C0;
    localparam logic [AW-1:0] X_INCR_HIGH   = 10'h1A4;
    localparam logic [AW-1:0] TEST_CTRL     = 10'h1F0;
    localparam logic [AW-1:0] GROUP_SEL     = 10'h1F4;
    localparam logic [AW-1:0] ST_EARLY_LATE = 10'h200;
    localparam logic [AW-1:0] ST_MEAS       = 10'h204;
    localparam logic [AW-1:0] ST_NEW_DATA   = 10'h208;
    localparam logic [AW-1:0] ST_MISSED     = 10'h20C;
    localparam logic [AW-1:0] ACC_BASE      = 10'h210;
    localparam logic [AW-1:0] ACC_STRIDE    = 10'h010;
    localparam logic [AW-1:0] MULTI_ACC     = 10'h2D0;
    localparam logic [AW-1:0] ALL_ACC       = 10'h2E0;
    localparam logic [AW-1:0] ACC_END       = 10'h2F0;
    // Offsets within a channel block
    localparam logic [4:0]  OFF_CODE_PHASE = 5'h04;
    localparam logic [4:0]  OFF_CARR_CYC   = 5'h08;
    localparam logic [4:0]  OFF_CARR_HI    = 5'h0C;
    localparam logic [4:0]  OFF_CARR_LO    = 5'h10;
    localparam logic [4:0]  OFF_CODE_HI    = 5'h14;
    localparam logic [4:0]  OFF_CODE_LO    = 5'h18;
    localparam logic [4:0]  OFF_ACC_RESET  = 5'h04;
    localparam logic [4:0]  OFF_Q_PROMPT   = 5'h0C;
    // Field positions
    localparam int          TEST_MODE_BIT = 3;
    localparam int          INT_FLAG_BIT  = 15;
    localparam int          GLITCH_BIT    = 15;
    localparam int          LEVEL_BIT     = 14;
    localparam int          EPOCH_BIT     = 13;
    localparam int          MEASUREMENT_INTERRUPT_FLAG_BIT  = 12;
    // ****************
    // Timing
    // ****************
    localparam int          PHASES        = 7;
    localparam int          CLK_MHZ       = 40;
    localparam int          WR_GAP_NS     = 300;
    localparam int          WR_GAP_CYC    = (WR_GAP_NS * CLK_MHZ + 999) / 1000;
    localparam int          GLITCH_NS     = 25;
    localparam int          GLITCH_CYC    = (GLITCH_NS * CLK_MHZ + 999) / 1000;
    localparam int          WARN_MS       = 50;
    localparam int          WARN_CYC      = WARN_MS * CLK_MHZ * 1000;
    localparam int          RD_CYC        = 2;
    // Host command registers (APB)
    localparam logic [7:0]  H_ADDR   = 8'h00;
    localparam logic [7:0]  H_DATA   = 8'h04;
    localparam logic [7:0]  H_GO     = 8'h08;
    localparam logic [7:0]  H_STATUS = 8'h0C;
endpackage
`default_nettype wire

// File: inc/crs_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface crs_link_if
    import crs_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn
);
    logic          wr_en;
    logic          rd_en;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;

    modport dev  (input pclk, presetn, wr_en, rd_en, addr, wdata, output rdata);
    modport host (input pclk, presetn, rdata, output wr_en, rd_en, addr, wdata);
endinterface
`default_nettype wire

// File: rtl/crs_host.sv
`timescale 1ns/1ps
`default_nettype none
module crs_host
    import crs_pkg::*;
(
    crs_link_if.host         link,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr
);
    // ****************
    // Command registers
    // ****************
    typedef enum logic [3:0] {
        HS_IDLE = 4'b0001,
        HS_WR   = 4'b0010,
        HS_RD   = 4'b0100,
        HS_GAP  = 4'b1000
    } crs_hst_e;

    crs_hst_e      st_r;
    logic [AW-1:0] caddr_r;
    logic [DW-1:0] cdata_r;
    logic [DW-1:0] res_r;
    logic [7:0]    cnt_r;
    logic          acc;
    logic          go;

    assign acc     = psel && penable;
    assign go      = acc && pwrite && paddr == H_GO && st_r == HS_IDLE;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;

    always_ff @(posedge link.pclk or negedge link.presetn) begin
        if (!link.presetn) begin
            caddr_r <= '0;
            cdata_r <= '0;
        end else if (acc && pwrite && paddr == H_ADDR) begin
            caddr_r <= pwdata[AW-1:0];
        end else if (acc && pwrite && paddr == H_DATA) begin
            cdata_r <= pwdata[DW-1:0];
        end
    end

    always_comb begin
        if (paddr == H_ADDR) begin
            prdata = 32'(caddr_r);
        end else if (paddr == H_DATA) begin
            prdata = 32'(cdata_r);
        end else if (paddr == H_STATUS) begin
            prdata = {res_r, 15'h0000, st_r != HS_IDLE};
        end else begin
            prdata = 32'h0000_0000;
        end
    end

    // ****************
    // Link sequencer
    // ****************
    always_ff @(posedge link.pclk or negedge link.presetn) begin
        if (!link.presetn) begin
            st_r       <= HS_IDLE;
            cnt_r      <= '0;
            res_r      <= '0;
            link.wr_en <= 1'b0;
            link.rd_en <= 1'b0;
            link.addr  <= '0;
            link.wdata <= '0;
        end else begin
            case (st_r)
                HS_IDLE: begin
                    if (go) begin
                        link.addr  <= caddr_r;
                        link.wdata <= cdata_r;
                        link.wr_en <= !pwdata[0];
                        link.rd_en <= pwdata[0];
                        cnt_r      <= 8'(RD_CYC - 1);
                        st_r       <= pwdata[0] ? HS_RD : HS_WR;
                    end
                end
                HS_WR: begin
                    link.wr_en <= 1'b0;
                    cnt_r      <= (link.addr == X_INCR_HIGH) ? 8'h00 : 8'(WR_GAP_CYC - 2);
                    st_r       <= (link.addr == X_INCR_HIGH) ? HS_IDLE : HS_GAP;
                end
                HS_RD: begin
                    if (cnt_r == 8'h00) begin
                        link.rd_en <= 1'b0;
                        res_r      <= link.rdata;
                        st_r       <= HS_IDLE;
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                HS_GAP: begin
                    if (cnt_r == 8'h00) begin
                        st_r <= HS_IDLE;
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                default: st_r <= HS_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// File: testbench/crs_link_checker.sv
`timescale 1ns/1ps
`default_nettype none
module crs_link_checker
    import crs_pkg::*;
(
    input wire logic          pclk,
    input wire logic          presetn,
    input wire logic          wr_en,
    input wire logic          rd_en,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wdata,
    input wire logic [DW-1:0] rdata
);
    // ****************
    // Link checks
    // ****************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic bcast;
    assign bcast = (addr >= MULTI_CHANNEL_CONTROL_BASE && addr < MULTI_CHANNEL_CONTROL_BASE + 10'h020)
                || (addr >= ALL_CHANNEL_CONTROL_BASE && addr < ALL_CHANNEL_CONTROL_BASE + 10'h020) || (addr >= MULTI_ACC && addr < ACC_END);
    sequence s_rd_start;
        $rose(rd_en);
    endsequence
    sequence s_rd_hold;
        rd_en [*2] ##1 !rd_en;
    endsequence
    a_write_pulse: assert property (wr_en |=> !wr_en)
        else $error("write strobe longer than one cycle");
    a_write_gap: assert property (wr_en && addr != X_INCR_HIGH |=> !wr_en [*8] ##1 !wr_en [*3])
        else $error("writes too close together");
    a_read_hold: assert property (s_rd_start |-> s_rd_hold)
        else $error("read strobe length wrong");
    a_read_addr: assert property (rd_en && $past(rd_en) |-> $stable(addr))
        else $error("address moved during read");
    a_no_overlap: assert property (!(wr_en && rd_en))
        else $error("read and write together");
    a_early_high: assert property (rd_en && addr == ST_EARLY_LATE |=> rdata[15:12] == 4'h0)
        else $error("early flags upper bits set");
    a_new_high: assert property (rd_en && addr == ST_NEW_DATA |=> rdata[14:12] == 3'h0)
        else $error("new data unused bits set");
    a_bcast_read: assert property (rd_en && bcast |=> rdata == 16'h0000)
        else $error("broadcast address returned data");
endmodule
`default_nettype wire

// File: testbench/test_correlator_status_register_bank.sv
`timescale 1ns/1ps
`default_nettype none
module test_correlator_status_register_bank
    import crs_pkg::*;
;
    // ****************
    // Stimulus and checks
    // ****************
    logic           pclk = 1'b0;
    logic           presetn = 1'b0;
    logic           psel = 1'b0;
    logic           penable = 1'b0;
    logic           pwrite = 1'b0;
    logic [7:0]     paddr = 8'h00;
    logic [31:0]    pwdata = 32'h0;
    logic [31:0]    prdata, q;
    logic           pready, pslverr;
    logic [NCH-1:0] dump = 12'h000;
    logic [NCH-1:0] early_code = 12'h000;
    logic [NCH-1:0] chan_enable = 12'hFFF;
    logic           integration_interrupt = 1'b0;
    logic           measurement_epoch = 1'b0;
    logic           interrupt_enable = 1'b0;
    logic           discrete_input_level = 1'b1;
    logic           software_master_reset = 1'b0;
    logic [DW-1:0]  meas_rdata = 16'h0000;
    logic [AW-1:0]  meas_addr;
    logic           wr_stb, wr_is_acc, incr_load, incr_is_code, test_mode;
    logic [NCH-1:0] wr_mask, incr_mask;
    logic [4:0]     wr_off;
    logic [DW-1:0]  wr_data, rv;
    logic [IW-1:0]  incr_value;
    int             n_errors = 0, n_tests = 0, cyc = 0, n_stb = 0, n_inc = 0, s;
    always #12.5 pclk = ~pclk;
    crs_link_if link (.pclk(pclk), .presetn(presetn));
    crs_host crs_host_i (.link(link), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    crs_device #(.WARN_CY(32'd20)) crs_device_i (.link(link), .dump(dump), .early_code(early_code),
        .chan_enable(chan_enable), .integration_interrupt(integration_interrupt),
        .measurement_epoch(measurement_epoch), .interrupt_enable(interrupt_enable),
        .discrete_input_level(discrete_input_level), .software_master_reset(software_master_reset),
        .meas_rdata(meas_rdata), .meas_addr(meas_addr), .wr_stb(wr_stb), .wr_mask(wr_mask), .wr_off(wr_off),
        .wr_is_acc(wr_is_acc), .wr_data(wr_data), .incr_load(incr_load), .incr_is_code(incr_is_code),
        .incr_mask(incr_mask), .incr_value(incr_value), .test_mode(test_mode));
    crs_link_checker crs_link_checker_i (.pclk(pclk), .presetn(presetn), .wr_en(link.wr_en),
        .rd_en(link.rd_en), .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata));
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (wr_stb === 1'b1) n_stb <= n_stb + 1;
        if (incr_load === 1'b1) n_inc <= n_inc + 1;
        if (cyc == 20000) begin
            n_errors++;
            summarize();
        end
    end
    task summarize;
        if (n_errors == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task chk(input logic [47:0] got, input logic [47:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        chk(pslverr, 1'b0);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task go(input logic [AW-1:0] a, input logic [31:0] cmd);
        apb(1'b1, H_ADDR, {22'h0, a});
        apb(1'b1, H_GO, cmd);
        apb(1'b0, H_STATUS, 32'h0);
        while (q[0] !== 1'b0) apb(1'b0, H_STATUS, 32'h0);
        rv = q[31:16];
    endtask
    task dev_wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        apb(1'b1, H_DATA, {16'h0, d});
        go(a, 32'h0);
    endtask
    task irq(input logic [NCH-1:0] m, input logic [NCH-1:0] e);
        @(posedge pclk);
        dump <= m;
        early_code <= e;
        @(posedge pclk);
        dump <= 12'h000;
        integration_interrupt <= 1'b1;
        @(posedge pclk);
        integration_interrupt <= 1'b0;
    endtask
    task t_incr;
        s = n_inc;
        dev_wr(AW'(OFF_CODE_HI), 16'h0123);
        dev_wr(GROUP_SEL, 16'h00A5);
        dev_wr(AW'(OFF_CODE_LO), 16'h4567);
        chk(incr_value, 32'h01234567);
        chk({incr_is_code, incr_mask}, {1'b1, 12'h001});
        dev_wr(X_INCR_HIGH, 16'h00AB);
        dev_wr(10'h040 + AW'(OFF_CARR_LO), 16'hCDEF);
        chk(incr_value, 32'h00ABCDEF);
        chk({incr_is_code, incr_mask}, {1'b0, 12'h004});
        chk(32'(n_inc - s), 32'd2);
    endtask
    task t_test_mode;
        s = n_stb;
        dev_wr(CHANNEL_CONTROL_BASE_STRIDE + AW'(OFF_CODE_PHASE), 16'h0055);
        chk(32'(n_stb - s), 32'd0);
        dev_wr(TEST_CTRL, 16'h0008);
        chk(test_mode, 1'b1);
        dev_wr(CHANNEL_CONTROL_BASE_STRIDE + AW'(OFF_CARR_CYC), 16'h0066);
        chk(32'(n_stb - s), 32'd1);
        chk({wr_is_acc, wr_off, wr_mask, wr_data}, {1'b0, OFF_CARR_CYC, 12'h002, 16'h0066});
        dev_wr(TEST_CTRL, 16'h0000);
    endtask
    task t_bcast;
        dev_wr(ALL_CHANNEL_CONTROL_BASE + 10'h01C, 16'h1234);
        chk({wr_is_acc, wr_off, wr_mask, wr_data}, {1'b0, 5'h1C, 12'hFFF, 16'h1234});
        dev_wr(MULTI_ACC, 16'h0077);
        chk({wr_is_acc, wr_off, wr_mask, wr_data}, {1'b1, 5'h00, 12'h0A5, 16'h0077});
        go(ALL_CHANNEL_CONTROL_BASE, 32'h1);
        chk(rv, 16'h0000);
        meas_rdata <= 16'hBEEF;
        go(10'h07C, 32'h1);
        chk({meas_addr, rv}, {10'h07C, 16'hBEEF});
    endtask
    task t_status;
        irq(12'h003, 12'h001);
        go(ST_NEW_DATA, 32'h1);
        chk(rv, 16'h8003);
        chan_enable <= 12'hFFD;
        go(ST_NEW_DATA, 32'h1);
        chk(rv, 16'h0001);
        chan_enable <= 12'hFFF;
        irq(12'h001, 12'h001);
        go(ST_MISSED, 32'h1);
        chk(rv[11:0], 12'h001);
        go(ST_EARLY_LATE, 32'h1);
        chk(rv, 16'h0001);
        go(ACC_BASE + AW'(OFF_Q_PROMPT), 32'h1);
        dev_wr(ST_EARLY_LATE, 16'h0000);
        go(ST_NEW_DATA, 32'h1);
        chk(rv, 16'h8000);
        go(ST_MISSED, 32'h1);
        chk(rv[11:0], 12'h001);
        dev_wr(ACC_BASE + AW'(OFF_ACC_RESET), 16'h0000);
        go(ST_MISSED, 32'h1);
        chk(rv[11:0], 12'h000);
        go(ST_EARLY_LATE, 32'h1);
        chk(rv, 16'h0000);
    endtask
    task t_flags;
        @(posedge pclk);
        interrupt_enable <= 1'b1;
        discrete_input_level <= 1'b0;
        @(posedge pclk);
        discrete_input_level <= 1'b1;
        measurement_epoch <= 1'b1;
        software_master_reset <= 1'b1;
        @(posedge pclk);
        measurement_epoch <= 1'b0;
        interrupt_enable <= 1'b0;
        go(ST_MISSED, 32'h1);
        chk(rv[15:12], 4'hF);
        discrete_input_level <= 1'b0;
        software_master_reset <= 1'b0;
        go(ST_MISSED, 32'h1);
        chk(rv[15:12], 4'h8);
        discrete_input_level <= 1'b1;
        interrupt_enable <= 1'b1;
        repeat (2000) @(posedge pclk);
        go(ST_MISSED, 32'h1);
        chk(rv[13:12], 2'b01);
    endtask
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_incr();
        t_test_mode();
        t_bcast();
        t_status();
        t_flags();
        summarize();
    end
endmodule
`default_nettype wire
